// file: design/rate_divider.sv
`include "pwm_timer_defines.svh"

module rate_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] rate_i,
    // Counter clock enable
    output logic tick_o
);
    import pwm_timer_pkg::*;

    div_state_t s_ff;
    div_state_t nxt;

    function automatic logic [7:0] last_of(input logic [2:0] rate);
        logic [8:0] div;
        div = `TMR_RATE_BASE >> rate;
        return 8'(div - 9'h001);
    endfunction : last_of

    always_comb begin
        nxt = s_ff;
        if (!run_i) begin
            nxt.cnt = 8'h00;
            nxt.tick = 1'b0;
        end else if (s_ff.cnt == last_of(rate_i)) begin
            nxt.cnt = 8'h00;
            nxt.tick = 1'b1;
        end else begin
            nxt.cnt = s_ff.cnt + 8'h01;
            nxt.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt;
        end
    end

    assign tick_o = s_ff.tick;

    sequence s_fast_tick;
        tick_o && run_i && rate_i == 3'h7 ##1 run_i && rate_i == 3'h7;
    endsequence

    a_div_by_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_fast_tick |=> tick_o)
        else $error("divide by two tick missing");

    a_tick_single: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tick_o |=> !tick_o)
        else $error("tick longer than one cycle");

endmodule : rate_divider

// file: design/timer_pwm.sv
// Function
// - Pin carries the waveform only while timer and pulse output are enabled.
// - Each period begins high unless duty is zero, then low; duty sets the high length.
// - Rate field sets period, resolution bits set steps, reload sets duty.
// - In pulse mode the count starts at zero on enable and after overflow.
// - When count equals active duty the output goes low.
// - Wrap from top to zero ends the period; output returns high unless the buffered duty is zero.
// - Buffered duty moves to active compare at enable and at each overflow; an idle timer copies it every cycle.
// - Resolution 00/01/10/11 gives 256/64/32/16 steps; overflow at that count.
// - Every overflow sets the overflow flag; request raised when enabled.
// - Pulse enable takes the pin; clearing it returns the pin to GPIO unless toggle output is set.
// - Clearing pulse enable gates the waveform off the pin; the timer keeps running.
// - Duty writes go to a holding buffer until the next overflow or timer enable; an idle timer copies them at once.
// - Rate codes 000 to 111 divide the clock by 256 down to 2.
// - Mode bits: 0 pulse enable, 1 toggle, 2 reload, 7 timer enable; reset zero.
`include "pwm_timer_defines.svh"

module timer_pwm (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire pwm_timer_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    // General-purpose drive of the shared pin
    input wire pwm_timer_pkg::pin_drive_t gpio_i,
    // Shared output pin
    output logic shared_output_pin_o,
    output logic shared_output_pin_oe_o,
    // Interrupt request
    output logic timer_irq_o
);
    import pwm_timer_pkg::*;

    timer_state_t s_ff;
    timer_state_t nxt;
    logic tick;
    logic start;
    logic ovf;
    logic pwm_mode;
    logic [7:0] top;
    logic [7:0] count_inc;

    function automatic logic [7:0] top_of(input logic aload, input logic tog);
        unique case ({aload, tog})
            2'b00: return `TMR_TOP_256;
            2'b01: return `TMR_TOP_64;
            2'b10: return `TMR_TOP_32;
            2'b11: return `TMR_TOP_16;
        endcase
    endfunction : top_of

    rate_divider u_rate_divider (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(s_ff.mode.timer_enable_bit),
        .rate_i(s_ff.mode.prescale_rate_field),
        .tick_o(tick)
    );

    assign pwm_mode = s_ff.mode.pulse_output_enable;
    assign start = s_ff.mode.timer_enable_bit && !s_ff.enable_d;
    assign count_inc = s_ff.timer_count_value + 8'h01;

    // Resolution only shortens the period in pulse mode
    always_comb begin
        if (pwm_mode) begin
            top = top_of(s_ff.mode.auto_reload_select, s_ff.mode.toggle_output_select);
        end else begin
            top = `TMR_TOP_256;
        end
    end

    assign ovf = s_ff.mode.timer_enable_bit && !start && tick && s_ff.timer_count_value == top;

    always_comb begin
        nxt = s_ff;
        nxt.enable_d = s_ff.mode.timer_enable_bit;
        nxt.rdata = 8'h00;

        // Idle timer keeps active duty equal to the buffer for the first period
        if (!s_ff.mode.timer_enable_bit) begin
            nxt.duty_reload_value = s_ff.duty_buffer;
        end

        if (start) begin
            if (pwm_mode) begin
                nxt.timer_count_value = 8'h00;
            end
            nxt.duty_reload_value = s_ff.duty_buffer;
            nxt.level = s_ff.duty_buffer != 8'h00;
        end else if (ovf) begin
            nxt.duty_reload_value = s_ff.duty_buffer;
            nxt.timer_overflow_flag = 1'b1;
            nxt.level = s_ff.duty_buffer != 8'h00;
            if (pwm_mode) begin
                nxt.timer_count_value = 8'h00;
            end else if (s_ff.mode.auto_reload_select) begin
                nxt.timer_count_value = s_ff.duty_buffer;
            end else begin
                nxt.timer_count_value = 8'h00;
            end
            if (!pwm_mode && s_ff.mode.toggle_output_select) begin
                nxt.toggle = !s_ff.toggle;
            end
        end else if (s_ff.mode.timer_enable_bit && tick) begin
            nxt.timer_count_value = count_inc;
            if (count_inc == s_ff.duty_reload_value) begin
                nxt.level = 1'b0;
            end
        end

        // Register writes; a count write wins over the counter
        if (req_i.wr) begin
            unique case (req_i.addr)
                `TMR_MODE_ADDR: nxt.mode = timer_mode_control_t'(req_i.wdata);
                `TMR_COUNT_ADDR: nxt.timer_count_value = req_i.wdata;
                `TMR_RELOAD_ADDR: nxt.duty_buffer = req_i.wdata;
                `TMR_STATUS_ADDR: begin
                    // Overflow in the same cycle beats the clear
                    nxt.timer_overflow_flag = ovf || (s_ff.timer_overflow_flag && req_i.wdata[`TMR_STAT_FLAG_BIT]);
                    nxt.timer_irq_enable = req_i.wdata[`TMR_STAT_IEN_BIT];
                end
                default: begin
                end
            endcase
        end

        if (req_i.rd) begin
            unique case (req_i.addr)
                `TMR_MODE_ADDR: nxt.rdata = s_ff.mode;
                `TMR_COUNT_ADDR: nxt.rdata = s_ff.timer_count_value;
                `TMR_STATUS_ADDR: begin
                    nxt.rdata[`TMR_STAT_FLAG_BIT] = s_ff.timer_overflow_flag;
                    nxt.rdata[`TMR_STAT_IEN_BIT] = s_ff.timer_irq_enable;
                end
                default: nxt.rdata = 8'h00;
            endcase
        end

        // Shared pin selection
        if (pwm_mode) begin
            nxt.pin.oe = 1'b1;
            nxt.pin.out = s_ff.mode.timer_enable_bit && s_ff.level;
        end else if (s_ff.mode.toggle_output_select) begin
            nxt.pin.oe = 1'b1;
            nxt.pin.out = s_ff.toggle;
        end else begin
            nxt.pin = gpio_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt;
        end
    end

    assign rdata_o = s_ff.rdata;
    assign shared_output_pin_o = s_ff.pin.out;
    assign shared_output_pin_oe_o = s_ff.pin.oe;
    assign timer_irq_o = s_ff.timer_overflow_flag && s_ff.timer_irq_enable;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_running_pwm;
        s_ff.mode.timer_enable_bit && s_ff.mode.pulse_output_enable;
    endsequence

    sequence s_match_quiet;
        s_running_pwm ##0 s_ff.timer_count_value == s_ff.duty_reload_value ##0 !$past(req_i.wr);
    endsequence

    a_pin_drive_pwm: assert property (
        s_running_pwm |=> shared_output_pin_oe_o && shared_output_pin_o == $past(s_ff.level))
        else $error("pulse waveform not on pin");

    a_pin_gpio_back: assert property (
        !s_ff.mode.pulse_output_enable && !s_ff.mode.toggle_output_select
        |=> shared_output_pin_o == $past(gpio_i.out) && shared_output_pin_oe_o == $past(gpio_i.oe))
        else $error("pin not returned to gpio");

    a_period_high: assert property (
        ovf && s_ff.duty_buffer != 8'h00 |=> s_ff.level ##1 s_ff.level || s_ff.timer_count_value != 8'h00)
        else $error("period did not start high");

    a_match_low: assert property (
        s_match_quiet |-> !s_ff.level)
        else $error("output high at duty match");

    a_restart_zero: assert property (
        start && s_ff.mode.pulse_output_enable && !req_i.wr |=> s_ff.timer_count_value == 8'h00)
        else $error("counter did not start at zero");

    a_wrap_zero: assert property (
        ovf && pwm_mode && !req_i.wr |=> s_ff.timer_count_value == 8'h00 && s_ff.timer_overflow_flag)
        else $error("pulse period did not wrap to zero");

    a_duty_load: assert property (
        ovf |=> s_ff.duty_reload_value == $past(s_ff.duty_buffer))
        else $error("duty not loaded at overflow");

    a_duty_hold: assert property (
        s_ff.mode.timer_enable_bit && !ovf && !start |=> s_ff.duty_reload_value == $past(s_ff.duty_reload_value))
        else $error("active duty changed mid period");

    a_top_count: assert property (
        ovf && pwm_mode |-> s_ff.timer_count_value
            == top_of(s_ff.mode.auto_reload_select, s_ff.mode.toggle_output_select))
        else $error("overflow at wrong count");

    a_flag_sticky: assert property (
        s_ff.timer_overflow_flag && !(req_i.wr && req_i.addr == `TMR_STATUS_ADDR) |=> s_ff.timer_overflow_flag)
        else $error("overflow flag lost");

    a_irq_follow: assert property (
        ovf && s_ff.timer_irq_enable && !req_i.wr |=> timer_irq_o)
        else $error("interrupt request missing");

    a_gate_keeps_count: assert property (
        s_ff.mode.timer_enable_bit && tick && !ovf && !start && !req_i.wr
        |=> s_ff.timer_count_value == $past(count_inc))
        else $error("timer stopped while gating");

endmodule : timer_pwm

// file: include/pwm_timer_defines.svh
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH

// Register offsets on the 8-bit register port
`define TMR_MODE_ADDR 8'hda
`define TMR_COUNT_ADDR 8'hdb
`define TMR_RELOAD_ADDR 8'hcd
`define TMR_STATUS_ADDR 8'hc8

// Status register field positions
`define TMR_STAT_FLAG_BIT 0
`define TMR_STAT_IEN_BIT 1

// Reset values
`define TMR_MODE_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_RELOAD_RESET 8'h00

// Prescaler: rate code 0 divides by this, each step halves it
`define TMR_RATE_BASE 9'h100

// Top counts per resolution code
`define TMR_TOP_256 8'hff
`define TMR_TOP_64 8'h3f
`define TMR_TOP_32 8'h1f
`define TMR_TOP_16 8'h0f

`endif

// file: include/pwm_timer_pkg.sv
package pwm_timer_pkg;

    // Mode register, bit 7 down to bit 0
    typedef struct packed {
        logic timer_enable_bit;
        logic [2:0] prescale_rate_field;
        logic clock_source_select;
        logic auto_reload_select;
        logic toggle_output_select;
        logic pulse_output_enable;
    } timer_mode_control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    typedef struct packed {
        timer_mode_control_t mode;
        logic [7:0] timer_count_value;
        logic [7:0] duty_buffer;
        logic [7:0] duty_reload_value;
        logic timer_overflow_flag;
        logic timer_irq_enable;
        logic level;
        logic toggle;
        logic enable_d;
        pin_drive_t pin;
        logic [7:0] rdata;
    } timer_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_state_t;

endpackage : pwm_timer_pkg

// file: verification/pwm_load.sv
module pwm_load (
    // Clock
    input wire logic clk_i,
    // Driven pin
    input wire logic pin_i,
    input wire logic pin_oe_i,
    // Measurement of the last full period
    output logic level_o,
    output logic done_o,
    output logic [15:0] high_o,
    output logic [15:0] per_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_ff = 1'b1;
    logic [15:0] hi_ff = 16'h0000;
    logic [15:0] cnt_ff = 16'h0000;
    // Released pin is pulled up
    assign level_o = pin_oe_i ? pin_i : 1'b1;
    always @(posedge clk_i) begin
        prev_ff <= level_o;
        done_o <= level_o && !prev_ff;
        if (level_o && !prev_ff) begin
            high_o <= hi_ff;
            per_o <= cnt_ff;
            hi_ff <= 16'h0001;
            cnt_ff <= 16'h0001;
        end else begin
            hi_ff <= hi_ff + 16'(level_o);
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule : pwm_load

// file: verification/timer_pwm_tb_top.sv
`include "pwm_timer_defines.svh"

module timer_pwm_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_timer_pkg::*;
    typedef struct packed {
        logic [7:0] m;
        logic [7:0] d;
        logic [15:0] h;
        logic [15:0] p;
    } row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    reg_req_t req = '0;
    pin_drive_t gpio = 2'b01;
    logic [7:0] rdata;
    logic pin;
    logic pin_oe;
    logic irq;
    logic level;
    logic done;
    logic [15:0] high;
    logic [15:0] per;
    logic [7:0] v1;
    logic [7:0] v2;
    int mismatches = 0;
    int cmp_count = 0;
    row_t rows [11] = '{
        '{8'hf1, 8'h80, 16'h0100, 16'h0200}, '{8'hf3, 8'h10, 16'h0020, 16'h0080},
        '{8'hf5, 8'h10, 16'h0020, 16'h0040}, '{8'h87, 8'h05, 16'h0500, 16'h1000},
        '{8'h97, 8'h05, 16'h0280, 16'h0800}, '{8'ha7, 8'h05, 16'h0140, 16'h0400},
        '{8'hb7, 8'h05, 16'h00a0, 16'h0200}, '{8'hc7, 8'h05, 16'h0050, 16'h0100},
        '{8'hd7, 8'h05, 16'h0028, 16'h0080}, '{8'he7, 8'h05, 16'h0014, 16'h0040},
        '{8'hf7, 8'h05, 16'h000a, 16'h0020}};

    timer_pwm timer_pwm_i (.clk_i(clk), .reset_n_i(reset_n), .req_i(req), .rdata_o(rdata), .gpio_i(gpio),
        .shared_output_pin_o(pin), .shared_output_pin_oe_o(pin_oe), .timer_irq_o(irq));
    pwm_load pwm_load_i (.clk_i(clk), .pin_i(pin), .pin_oe_i(pin_oe), .level_o(level), .done_o(done),
        .high_o(high), .per_o(per));

    always #2.5 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, v1);
        chk(v1, exp);
    endtask : rdchk

    task automatic wait_done(input int n);
        int t;
        repeat (n) begin
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (done !== 1'b1 && t < 20000);
            if (t >= 20000) begin
                mismatches++;
                end_of_test;
            end
        end
    endtask : wait_done

    task automatic run_row(input row_t r);
        wr(`TMR_MODE_ADDR, 8'h00);
        wr(`TMR_MODE_ADDR, r.m & 8'h76);
        wr(`TMR_RELOAD_ADDR, r.d);
        wr(`TMR_COUNT_ADDR, 8'h00);
        wr(`TMR_MODE_ADDR, r.m & 8'hfe);
        wr(`TMR_MODE_ADDR, r.m);
        rdchk(`TMR_MODE_ADDR, r.m);
        wait_done(3);
        chk(high, r.h);
        chk(per, r.p);
        rdchk(`TMR_STATUS_ADDR, 8'h01);
        wr(`TMR_STATUS_ADDR, 8'h00);
    endtask : run_row

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5) @(posedge clk);
        chk({rdata, pin_oe, irq}, 10'h000);
        reset_n <= 1'b1;
        rdchk(`TMR_MODE_ADDR, 8'h00);
        rdchk(`TMR_COUNT_ADDR, 8'h00);
        rdchk(8'h00, 8'h00);
        rdchk(`TMR_RELOAD_ADDR, 8'h00);
        for (int i = 0; i < 11; i++) begin
            run_row(rows[i]);
        end
        // Duty change while the output runs
        wr(`TMR_RELOAD_ADDR, 8'h09);
        wait_done(1);
        chk(high, 16'h000a);
        wait_done(1);
        chk(high, 16'h0012);
        wr(`TMR_STATUS_ADDR, 8'h02);
        wait_done(1);
        #1 chk(irq, 1'b1);
        wr(`TMR_STATUS_ADDR, 8'h02);
        #1 chk(irq, 1'b0);
        // Pin back to port logic, timer keeps counting
        gpio <= 2'b11;
        wr(`TMR_MODE_ADDR, 8'hf4);
        repeat (2) @(posedge clk);
        #1 chk({pin, pin_oe}, 2'b11);
        rd(`TMR_COUNT_ADDR, v1);
        rd(`TMR_COUNT_ADDR, v2);
        chk(v1 != v2, 1'b1);
        wr(`TMR_MODE_ADDR, 8'hf7);
        repeat (2) @(posedge clk);
        #1 chk(pin_oe, 1'b1);
        wr(`TMR_MODE_ADDR, 8'h77);
        repeat (3) @(posedge clk);
        #1 chk({pin, pin_oe}, 2'b01);
        wr(8'h01, 8'h55);
        rdchk(`TMR_MODE_ADDR, 8'h77);
        reset_n <= 1'b0;
        #1 chk({pin_oe, irq}, 2'b00);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(`TMR_MODE_ADDR, 8'h00);
        end_of_test;
    end

    initial begin
        #500000;
        mismatches++;
        end_of_test;
    end
endmodule : timer_pwm_tb_top
